// ### common/touch_pkg.sv
// Constants, register map and carrier types for the touch panel readout sequencer.
// Assumes a 100 MHz system clock and an Avalon-MM slave with 32-bit data.
package touch_pkg;

    // Timing
    localparam int    CLK_MHZ            = 100;
    localparam int    DEBOUNCE_MS        = 30;
    localparam int    DEBOUNCE_CYCLES    = DEBOUNCE_MS * 1000 * CLK_MHZ;

    // Register byte addresses (word aligned)
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_DELAY    = 8'h04;
    localparam logic [7:0] ADDR_START    = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_MASK     = 8'h10;
    localparam logic [7:0] ADDR_POINTER  = 8'h14;
    localparam logic [7:0] ADDR_RESULT   = 8'h18;
    localparam logic [7:0] ADDR_SENSE    = 8'h1c;

    // Control register fields
    localparam int    CTRL_MODE_LSB      = 0;
    localparam int    CTRL_GROUP_SEL     = 3;
    localparam int    CTRL_CONV_EN       = 4;
    localparam int    CTRL_REF_EN        = 5;
    localparam logic [5:0] CTRL_RESET    = 6'h00;

    // Delay register fields: pre delay [15:0], inter delay select [17:16]
    localparam int    DELAY_PRE_LSB      = 0;
    localparam int    DELAY_INTER_LSB    = 16;
    localparam logic [15:0] PRE_RESET    = 16'h0010;

    // Result pointer fields
    localparam int    PTR_SECOND_LSB     = 4;

    // Status / mask bits
    localparam int    ST_DONE_PRIMARY    = 0;
    localparam int    ST_DONE_SECOND     = 1;
    localparam int    ST_PEN             = 2;
    localparam int    ST_WIDTH           = 3;

    // Mode codes
    localparam logic [2:0] MODE_INTERRUPT = 3'h1;
    localparam logic [2:0] MODE_RESERVED_IRQ = 3'h5;

    // General purpose channel number of the first of the four plate pins
    localparam logic [2:0] GP_CHAN_X1    = 3'h4;

    // Conversion slots
    localparam int    SLOTS              = 8;
    localparam int    ADC_BITS           = 10;

    // Switch matrix setting for one conversion
    typedef enum logic [2:0] {
        SW_OPEN    = 3'b000,
        SW_X_READ  = 3'b001,
        SW_Y_READ  = 3'b010,
        SW_R_READ  = 3'b011,
        SW_PEN     = 3'b100,
        SW_GENERAL = 3'b101
    } switch_t;

    typedef struct packed {
        logic       start;
        logic [2:0] channel;
        switch_t    matrix;
    } conv_req_t;

    typedef struct packed {
        logic                done;
        logic [ADC_BITS-1:0] data;
    } conv_ans_t;

endpackage

// ### src/pen_debounce.sv
// Dual-edge pen contact debouncer.
// Assumes the contact level is synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module pen_debounce #(
    parameter int COUNT = touch_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic enable,
    input  wire logic contact,
    output logic      stable,
    output logic      edge_seen
);
    logic [31:0] count;
    wire         differs = contact != stable;
    wire         expired = count >= 32'(COUNT - 1);

    // Level must hold a full window before it is accepted; either edge counts
    always_ff @(posedge mclk) begin
        if (!resetn || !enable) begin
            count     <= 32'h0;
            edge_seen <= 1'b0;
            if (!resetn)
                stable <= 1'b0;
        end else begin
            edge_seen <= differs && expired;
            if (!differs)
                count <= 32'h0;
            else if (expired) begin
                count  <= 32'h0;
                stable <= contact;
            end else
                count <= count + 32'h1;
        end
    end
endmodule // pen_debounce
`default_nettype wire

// ### src/touch_sequencer.sv
// Eight-slot touch conversion sequencer with its own result store.
// Assumes the converter answers each start with one done pulse.
`timescale 1ns/1ns
`default_nettype none
module touch_sequencer #(
    parameter int DW = touch_pkg::ADC_BITS
) (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  go,
    input  wire logic [15:0]           pre_delay,
    input  wire logic [1:0]            inter_sel,
    input  wire touch_pkg::conv_ans_t  ans,
    output touch_pkg::conv_req_t       req,
    output logic                       busy,
    output logic                       finished,
    input  wire logic [2:0]            rd_addr_a,
    input  wire logic [2:0]            rd_addr_b,
    output logic [DW-1:0]              rd_data_a,
    output logic [DW-1:0]              rd_data_b
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WAIT = 2'b01,
        S_CONV = 2'b10
    } seq_t;

    seq_t          state;
    logic [2:0]    slot;
    logic [17:0]   timer;
    logic [DW-1:0] store [touch_pkg::SLOTS];

    function automatic touch_pkg::switch_t slot_matrix(input logic [2:0] s);
        case (s)
            3'h0, 3'h1: slot_matrix = touch_pkg::SW_X_READ;
            3'h3, 3'h4: slot_matrix = touch_pkg::SW_Y_READ;
            3'h6, 3'h7: slot_matrix = touch_pkg::SW_R_READ;
            default:    slot_matrix = touch_pkg::SW_OPEN;
        endcase
    endfunction

    wire        is_dummy   = slot_matrix(slot) == touch_pkg::SW_OPEN;
    wire [17:0] inter_wait = 18'h0010 << inter_sel;
    wire        timer_zero = timer == 18'h0;

    assign rd_data_a = store[rd_addr_a];
    assign rd_data_b = store[rd_addr_b];
    assign busy      = state != S_IDLE;

    always_ff @(posedge mclk) begin
        finished  <= 1'b0;
        req.start <= 1'b0;
        if (!resetn) begin
            state      <= S_IDLE;
            slot       <= 3'h0;
            timer      <= 18'h0;
            req        <= '0;
            for (int i = 0; i < touch_pkg::SLOTS; i++)
                store[i] <= '0;
        end else begin
            case (state)
                S_IDLE: if (go) begin
                    slot  <= 3'h0;
                    timer <= {2'b00, pre_delay};
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    req.matrix  <= slot_matrix(slot);
                    req.channel <= 3'h0;
                    if (timer_zero) begin
                        req.start <= !is_dummy;
                        state     <= S_CONV;
                    end else
                        timer <= timer - 18'h1;
                end
                S_CONV: if (is_dummy || ans.done) begin
                    // Dummy slot issues no start and stores zero
                    store[slot] <= is_dummy ? '0 : ans.data;
                    if (slot == 3'h7) begin
                        finished   <= 1'b1;
                        req.matrix <= touch_pkg::SW_OPEN;
                        state      <= S_IDLE;
                    end else begin
                        slot  <= slot + 3'h1;
                        timer <= inter_wait;
                        state <= S_WAIT;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // touch_sequencer
`default_nettype wire

// ### src/touch_readout.sv
// Top of the touch panel readout block: Avalon-MM register slave, mode decode, pen
// detection and the conversion sequencer. Assumes a shared converter answering on conv_ans.
`timescale 1ns/1ns
`default_nettype none
module touch_readout #(
    parameter int DEBOUNCE = touch_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    output logic [1:0]                avs_response,
    input  wire logic                 external_trigger_pin,
    input  wire logic                 pen_contact,
    input  wire touch_pkg::conv_ans_t conv_ans,
    output touch_pkg::conv_req_t      conv_req,
    output logic                      panel_reference_enable,
    output logic                      adc_input_group_select,
    output logic                      pen_detect_bias,
    output logic                      irq
);
    logic [5:0]               ctrl;
    logic [15:0]              pre_conversion_delay;
    logic [1:0]               inter_conversion_delay_select;
    logic [2:0]               result_pointer_primary;
    logic [2:0]               result_pointer_secondary;
    logic [touch_pkg::ST_WIDTH-1:0] status;
    logic [touch_pkg::ST_WIDTH-1:0] mask;
    logic                     trig_prev;
    logic                     requester;
    logic                     answered;
    logic                     gp_busy;

    // Decode
    wire [2:0] panel_mode_field  = ctrl[touch_pkg::CTRL_MODE_LSB +: 3];
    wire       converter_enable  = ctrl[touch_pkg::CTRL_CONV_EN];
    wire       mode_inactive     = panel_mode_field[1:0] == 2'b00;
    wire       mode_pen          = panel_mode_field == touch_pkg::MODE_INTERRUPT;
    wire       mode_touch        = panel_mode_field[1] && !panel_mode_field[2];
    wire       hit_ctrl          = avs_address == touch_pkg::ADDR_CTRL;
    wire       hit_delay         = avs_address == touch_pkg::ADDR_DELAY;
    wire       hit_start         = avs_address == touch_pkg::ADDR_START;
    wire       hit_status        = avs_address == touch_pkg::ADDR_STATUS;
    wire       hit_mask          = avs_address == touch_pkg::ADDR_MASK;
    wire       hit_pointer       = avs_address == touch_pkg::ADDR_POINTER;
    wire       hit_result        = avs_address == touch_pkg::ADDR_RESULT;
    wire       hit_sense         = avs_address == touch_pkg::ADDR_SENSE;
    wire       hit_any           = hit_ctrl | hit_delay | hit_start | hit_status | hit_mask
                                   | hit_pointer | hit_result | hit_sense;
    wire       access            = (avs_read | avs_write) && !answered;
    wire       wr                = avs_write && !answered && avs_byteenable[0];
    wire       trig_edge         = external_trigger_pin && !trig_prev;
    wire       sw_start          = wr && hit_start && avs_writedata[0];
    wire       sw_second         = avs_writedata[1];
    // Trigger gated by converter enable
    wire       trigger           = converter_enable && (trig_edge || sw_start);

    // Pen detect
    logic pen_level;
    logic pen_event;
    pen_debounce #(
        .COUNT     (DEBOUNCE)
    ) u_pen (
        .mclk      (mclk),
        .resetn    (resetn),
        .enable    (mode_pen),
        .contact   (pen_contact),
        .stable    (pen_level),
        .edge_seen (pen_event)
    );

    // Sequencer
    touch_pkg::conv_req_t seq_req;
    logic                 seq_busy;
    logic                 seq_done;
    logic [9:0]           data_a;
    logic [9:0]           data_b;
    touch_sequencer u_seq (
        .mclk      (mclk),
        .resetn    (resetn),
        .go        (trigger && mode_touch && !seq_busy && !gp_busy),
        .pre_delay (pre_conversion_delay),
        .inter_sel (inter_conversion_delay_select),
        .ans       (conv_ans),
        .req       (seq_req),
        .busy      (seq_busy),
        .finished  (seq_done),
        .rd_addr_a (result_pointer_primary),
        .rd_addr_b (result_pointer_secondary),
        .rd_data_a (data_a),
        .rd_data_b (data_b)
    );

    // General purpose single conversion on a plate pin in inactive mode
    logic [9:0] gp_result;
    wire        gp_go   = trigger && mode_inactive && !seq_busy && !gp_busy;
    wire        gp_done = gp_busy && conv_ans.done;
    wire        any_done = seq_done || gp_done;

    wire [touch_pkg::ST_WIDTH-1:0] done_bits = {1'b0, requester, !requester};
    wire [touch_pkg::ST_WIDTH-1:0] events    = (any_done ? done_bits : 3'h0)
                                               | {pen_event, 2'b00};
    wire [touch_pkg::ST_WIDTH-1:0] clr_bits  = (wr && hit_status)
                                               ? avs_writedata[touch_pkg::ST_WIDTH-1:0] : 3'h0;

    wire [31:0] rd_mux =
        hit_ctrl    ? {26'h0, ctrl} :
        hit_delay   ? {14'h0, inter_conversion_delay_select, pre_conversion_delay} :
        hit_start   ? {31'h0, seq_busy | gp_busy} :
        hit_status  ? {29'h0, status} :
        hit_mask    ? {29'h0, mask} :
        hit_pointer ? {25'h0, result_pointer_secondary, 1'b0, result_pointer_primary} :
        hit_result  ? {6'h0, data_b, 6'h0, data_a} :
        hit_sense   ? {22'h0, gp_result} : 32'h0;

    // One wait cycle per access keeps read data registered
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            answered        <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
            avs_response    <= 2'b00;
        end else begin
            answered        <= access;
            avs_waitrequest <= !access;
            avs_readdata    <= (access && avs_read) ? rd_mux : 32'h0;
            avs_response    <= (access && !hit_any) ? 2'b11 : 2'b00;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl                          <= touch_pkg::CTRL_RESET;
            pre_conversion_delay          <= touch_pkg::PRE_RESET;
            inter_conversion_delay_select <= 2'b00;
            result_pointer_primary        <= 3'h0;
            result_pointer_secondary      <= 3'h0;
            mask                          <= 3'h0;
        end else if (wr) begin
            if (hit_ctrl)
                ctrl <= avs_writedata[5:0];
            if (hit_delay) begin
                pre_conversion_delay          <= avs_writedata[touch_pkg::DELAY_PRE_LSB +: 16];
                inter_conversion_delay_select <= avs_writedata[touch_pkg::DELAY_INTER_LSB +: 2];
            end
            if (hit_pointer) begin
                result_pointer_primary   <= avs_writedata[2:0];
                result_pointer_secondary <= avs_writedata[touch_pkg::PTR_SECOND_LSB +: 3];
            end
            if (hit_mask)
                mask <= avs_writedata[touch_pkg::ST_WIDTH-1:0];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status    <= 3'h0;
            irq       <= 1'b0;
            trig_prev <= 1'b0;
            requester <= 1'b0;
        end else begin
            status    <= (status & ~clr_bits) | events;
            irq       <= |(((status & ~clr_bits) | events) & mask);
            trig_prev <= external_trigger_pin;
            if (sw_start && converter_enable && !seq_busy && !gp_busy)
                requester <= sw_second;
            else if (trig_edge && converter_enable && !seq_busy && !gp_busy)
                requester <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            gp_busy                <= 1'b0;
            gp_result              <= 10'h000;
            conv_req               <= '0;
            panel_reference_enable <= 1'b0;
            adc_input_group_select <= 1'b0;
            pen_detect_bias        <= 1'b0;
        end else begin
            adc_input_group_select <= ctrl[touch_pkg::CTRL_GROUP_SEL];
            // Reference follows its own bit; only touch readings need it
            panel_reference_enable <= ctrl[touch_pkg::CTRL_REF_EN];
            pen_detect_bias        <= mode_pen;
            if (gp_go) begin
                gp_busy          <= 1'b1;
                conv_req.start   <= 1'b1;
                conv_req.matrix  <= touch_pkg::SW_GENERAL;
                conv_req.channel <= touch_pkg::GP_CHAN_X1 + {1'b0, avs_writedata[3:2]};
            end else if (seq_busy) begin
                conv_req <= seq_req;
            end else begin
                conv_req.start  <= 1'b0;
                conv_req.matrix <= mode_pen ? touch_pkg::SW_PEN : touch_pkg::SW_OPEN;
            end
            if (gp_done) begin
                gp_busy   <= 1'b0;
                gp_result <= conv_ans.data;
            end
        end
    end
endmodule // touch_readout
`default_nettype wire

// ### verification/touch_readout_props.sv
// Concurrent checks on the touch readout top ports.
// Assumes requests held until waitrequest drops.
`timescale 1ns/1ns
`default_nettype none
module touch_readout_props (
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire logic [7:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    input wire logic [1:0]           avs_response,
    input wire touch_pkg::conv_req_t conv_req,
    input wire logic                 adc_input_group_select,
    input wire logic                 irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic en_seen;
    logic grp_seen;
    wire  ctrl_wr = avs_write && !avs_waitrequest && avs_address == touch_pkg::ADDR_CTRL && avs_byteenable[0];
    // Control bits seen at the accepting edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            en_seen  <= 1'b0;
            grp_seen <= 1'b0;
        end else if (ctrl_wr) begin
            en_seen  <= avs_writedata[touch_pkg::CTRL_CONV_EN];
            grp_seen <= avs_writedata[touch_pkg::CTRL_GROUP_SEL];
        end
    end
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("late bus answer");
    a_bus_response: assert property ((avs_read || avs_write) && !avs_waitrequest
        |-> avs_response == ((avs_address > touch_pkg::ADDR_SENSE) ? 2'h3 : 2'h0))
        else $error("bad response");
    a_idle_readdata: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("stray read data");
    a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start too long");
    a_start_matrix: assert property (conv_req.start |-> conv_req.matrix inside
        {touch_pkg::SW_X_READ, touch_pkg::SW_Y_READ, touch_pkg::SW_R_READ, touch_pkg::SW_GENERAL})
        else $error("start without matrix");
    a_general_channel: assert property (conv_req.start && conv_req.matrix == touch_pkg::SW_GENERAL
        |-> conv_req.channel >= 3'h4) else $error("general channel out of range");
    a_start_needs_en: assert property (!en_seen |-> !conv_req.start)
        else $error("start while disabled");
    a_group_follows: assert property (ctrl_wr |=> ##1 adc_input_group_select == grp_seen)
        else $error("group select stale");
    cover property (conv_req.start && conv_req.matrix == touch_pkg::SW_R_READ);
    cover property ($rose(irq));
    cover property (!avs_waitrequest && avs_response == 2'h3);
endmodule // touch_readout_props

bind touch_readout touch_readout_props props_u (.mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .conv_req, .adc_input_group_select, .irq);
`default_nettype wire

// ### verification/conv_model.sv
// Behavioural shared converter: one done pulse per start.
// Assumes one start at a time; latency alternates prompt and slow.
`timescale 1ns/1ns
`default_nettype none
module conv_model (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire touch_pkg::conv_req_t req,
    output touch_pkg::conv_ans_t      ans
);
    int                   n_start;
    int                   wait_left;
    logic                 slow;
    touch_pkg::conv_req_t last;
    logic [9:0]           code;
    always_comb begin
        case (last.matrix)
            touch_pkg::SW_X_READ: code = 10'h155;
            touch_pkg::SW_Y_READ: code = 10'h2aa;
            touch_pkg::SW_R_READ: code = 10'h0c3;
            default:              code = {7'h20, last.channel};
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            n_start   <= 0;
            wait_left <= 0;
            slow      <= 1'b0;
            last      <= '0;
            ans       <= '0;
        end else begin
            ans.done <= 1'b0;
            ans.data <= ~ans.data;
            if (req.start) begin
                n_start   <= n_start + 1;
                last      <= req;
                wait_left <= slow ? 6 : 1;
                slow      <= !slow;
            end else if (wait_left == 1) begin
                ans.done  <= 1'b1;
                ans.data  <= code;
                wait_left <= 0;
            end else if (wait_left > 1) begin
                wait_left <= wait_left - 1;
            end
        end
    end
endmodule // conv_model
`default_nettype wire

// ### verification/touch_readout_tb_top.sv
// Self-checking bench for the touch readout block.
// Assumes the one-wait bus answer and the register map.
`timescale 1ns/1ns
`default_nettype none
module touch_readout_tb_top;
    localparam int DEB = 20;
    logic                 mclk;
    logic                 resetn;
    logic [7:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [1:0]           avs_response;
    logic                 trig;
    logic                 pen;
    touch_pkg::conv_ans_t ans;
    touch_pkg::conv_req_t req;
    logic                 irq;
    logic                 ref_en;
    logic                 bias;
    logic [31:0]          rd;
    logic [1:0]           rr;
    int                   n_mismatch;
    int                   check_count;
    touch_readout #(.DEBOUNCE(DEB)) dut_u (.mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .external_trigger_pin(trig),
        .pen_contact(pen), .conv_ans(ans), .conv_req(req), .panel_reference_enable(ref_en),
        .adc_input_group_select(), .pen_detect_bias(bias), .irq);
    conv_model conv_u (.mclk, .resetn, .req, .ans);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= we;
        avs_read      <= !we;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        rr = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50)
            n_mismatch++;
    endtask
    task automatic poll_status;
        rd = 32'h0;
        for (int n = 0; n < 300 && rd === 32'h0; n++)
            bus(1'b0, touch_pkg::ADDR_STATUS, 32'h0);
    endtask
    task automatic kick(input bit ext, input logic [31:0] start);
        if (ext) begin
            trig <= 1'b1;
            @(posedge mclk);
            trig <= 1'b0;
        end else
            bus(1'b1, touch_pkg::ADDR_START, start);
    endtask
    function automatic logic [9:0] slot(input int i);
        case (i)
            0, 1: slot = 10'h155;
            3, 4: slot = 10'h2aa;
            6, 7: slot = 10'h0c3;
            default: slot = 10'h0;
        endcase
    endfunction
    task automatic t_regs;
        bus(1'b0, touch_pkg::ADDR_DELAY, 32'h0);
        check("delay reset", rd, {16'h0, touch_pkg::PRE_RESET});
        bus(1'b1, 8'h20, 32'hffff_ffff);
        check("unmapped write", {30'h0, rr}, 32'h3);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped read", rd, 32'h0);
    endtask
    task automatic t_idle(input logic [31:0] ctrl, input bit ext);
        int s0;
        s0 = conv_u.n_start;
        bus(1'b1, touch_pkg::ADDR_CTRL, ctrl);
        bus(1'b1, touch_pkg::ADDR_MASK, 32'h7);
        kick(ext, 32'h1);
        repeat (200) @(posedge mclk);
        check("no start", 32'(conv_u.n_start - s0), 32'h0);
        check("irq quiet", 32'(irq), 32'h0);
    endtask
    task automatic t_touch(input logic [31:0] ctrl, input bit ext, input logic [31:0] start,
                           input logic [31:0] st, input bit chk);
        int s0;
        int n;
        s0 = conv_u.n_start;
        bus(1'b1, touch_pkg::ADDR_MASK, 32'h0);
        bus(1'b1, touch_pkg::ADDR_CTRL, ctrl);
        bus(1'b1, touch_pkg::ADDR_DELAY, 32'h0001_0008);
        check("ref enable", 32'(ref_en), 32'(ctrl[5]));
        kick(ext, start);
        for (n = 0; n < 100 && req.start !== 1'b1; n++)
            @(posedge mclk);
        check("pre delay", 32'(n >= 8 && n <= 20), 32'h1);
        poll_status;
        check("done status", rd, st);
        check("starts", 32'(conv_u.n_start - s0), 32'h6);
        check("masked irq", 32'(irq), 32'h0);
        bus(1'b1, touch_pkg::ADDR_MASK, st);
        bus(1'b0, touch_pkg::ADDR_STATUS, 32'h0);
        check("unmasked irq", 32'(irq), 32'h1);
        for (int i = 0; chk && i < 8; i++) begin
            bus(1'b1, touch_pkg::ADDR_POINTER, {25'h0, 3'(7 - i), 1'b0, 3'(i)});
            bus(1'b0, touch_pkg::ADDR_RESULT, 32'h0);
            check("result", rd, {6'h0, slot(7 - i), 6'h0, slot(i)});
        end
        bus(1'b1, touch_pkg::ADDR_STATUS, st);
        bus(1'b0, touch_pkg::ADDR_STATUS, 32'h0);
        check("status cleared", rd, 32'h0);
        check("irq cleared", 32'(irq), 32'h0);
    endtask
    task automatic t_general;
        bus(1'b1, touch_pkg::ADDR_CTRL, 32'h18);
        for (int off = 0; off < 4; off++) begin
            bus(1'b1, touch_pkg::ADDR_START, 32'(1 + 4 * off));
            poll_status;
            check("gp channel", {29'h0, conv_u.last.channel}, 32'(4 + off));
            check("gp matrix", {29'h0, conv_u.last.matrix}, {29'h0, touch_pkg::SW_GENERAL});
            bus(1'b0, touch_pkg::ADDR_SENSE, 32'h0);
            check("gp result", rd, 32'(256 + 4 + off));
            bus(1'b1, touch_pkg::ADDR_STATUS, 32'h1);
        end
    endtask
    task automatic t_pen;
        int n;
        bus(1'b1, touch_pkg::ADDR_CTRL, 32'h1);
        bus(1'b1, touch_pkg::ADDR_MASK, 32'h4);
        check("pen bias", 32'(bias), 32'h1);
        pen <= 1'b1;
        repeat (DEB / 2) @(posedge mclk);
        pen <= 1'b0;
        repeat (2 * DEB) @(posedge mclk);
        check("pen glitch", 32'(irq), 32'h0);
        for (int k = 0; k < 2; k++) begin
            pen <= !pen;
            for (n = 0; n < 3 * DEB && irq !== 1'b1; n++)
                @(posedge mclk);
            check("pen irq", 32'(irq), 32'h1);
            check("debounce", 32'(n >= DEB && n <= DEB + 4), 32'h1);
            bus(1'b1, touch_pkg::ADDR_STATUS, 32'h4);
            bus(1'b0, touch_pkg::ADDR_STATUS, 32'h0);
            check("pen clear", rd, 32'h0);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        resetn         = 1'b0;
        avs_address    = 8'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        trig           = 1'b0;
        pen            = 1'b0;
        n_mismatch     = 0;
        check_count    = 0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_regs;
        t_idle(32'h15, 1'b0);
        t_idle(32'h16, 1'b1);
        t_idle(32'h17, 1'b0);
        t_idle(32'h02, 1'b0);
        t_idle(32'h02, 1'b1);
        t_touch(32'h3a, 1'b0, 32'h1, 32'h1, 1'b1);
        t_touch(32'h3b, 1'b1, 32'h0, 32'h1, 1'b0);
        t_touch(32'h3a, 1'b0, 32'h3, 32'h2, 1'b0);
        t_general;
        t_pen;
        tally_and_finish;
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // touch_readout_tb_top
`default_nettype wire
